// File: src/rx_fifo_irq_pkg.sv
/*
 * Shared constants for the receive link FIFO status and interrupt block:
 * register byte addresses, field positions, condition codes, reset values.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package rx_fifo_irq_pkg;

    // ==========================================================
    // widths
    localparam int ADR_W  = 8;
    localparam int DAT_W  = 32;
    localparam int CODE_W = 2;
    localparam int EVT_W  = 3;

    // ==========================================================
    // register byte addresses
    localparam logic [ADR_W-1:0] ADR_STATUS  = 8'h2C;  // link_interrupt_request_status
    localparam logic [ADR_W-1:0] ADR_MASK    = 8'h30;  // mask for the code field
    localparam logic [ADR_W-1:0] ADR_EVT     = 8'h34;  // sticky event status
    localparam logic [ADR_W-1:0] ADR_EVT_EN  = 8'h38;  // event enable
    localparam logic [ADR_W-1:0] ADR_EVT_CLR = 8'h3C;  // event clear, write only

    // ==========================================================
    // field positions
    localparam int CODE_LSB = 3;
    localparam int CODE_MSB = 4;
    localparam int EVT_HALF = 0;
    localparam int EVT_FULL = 1;
    localparam int EVT_OVF  = 2;

    // ==========================================================
    // condition codes, ordered by severity
    typedef enum logic [CODE_W-1:0] {
        COND_NORMAL = 2'h0,
        COND_HALF   = 2'h1,
        COND_FULL   = 2'h2,
        COND_OVF    = 2'h3
    } cond_type;

    // ==========================================================
    // reset values
    localparam logic [CODE_W-1:0] CODE_RST = 2'h0;
    localparam logic [CODE_W-1:0] MASK_RST = 2'h0;
    localparam logic [EVT_W-1:0]  EVT_RST  = 3'h0;
    localparam logic [DAT_W-1:0]  DAT_ZERO = 32'h0000_0000;

    // more severe of two codes; the encoding is ordered so compare is enough
    function automatic logic [CODE_W-1:0] sevMax(input logic [CODE_W-1:0] a,
                                                 input logic [CODE_W-1:0] b);
        sevMax = (a > b) ? a : b;
    endfunction : sevMax

endpackage : rx_fifo_irq_pkg

// File: src/rx_fifo_cond_encode.sv
/*
 * Encodes the present receive FIFO condition into the two-bit code.
 * Assumes level flags and an overflow pulse from FIFO logic on the same clock.
 */
`timescale 1ns/10ps

module rx_fifo_cond_encode (
    // fifo condition
    input  wire logic                                 halfFull,
    input  wire logic                                 fifoFull,
    input  wire logic                                 overflow,
    // encoded condition
    output      logic [rx_fifo_irq_pkg::CODE_W-1:0]  condNow
);
    import rx_fifo_irq_pkg::*;

    // ==========================================================
    // priority encode, worst condition first
    always_comb begin
        if (overflow) begin
            condNow = COND_OVF;          // R1
        end else if (fifoFull) begin
            condNow = COND_FULL;         // R1
        end else if (halfFull) begin
            condNow = COND_HALF;         // R1
        end else begin
            condNow = COND_NORMAL;       // R1
        end
    end

endmodule : rx_fifo_cond_encode

// File: src/rx_link_fifo_irq_status.sv
/*
 * Status and interrupt logic for the receive maintenance data link FIFO,
 * with a classic Wishbone register slave and one level interrupt output.
 * Assumes FIFO flags come from logic on clk and the bus master is classic.
 */
// The Wishbone interface to the registers was decided locally.
// Behaviour
// R1: the field codes 00 below half, 01 half or more, 10 full, 11 overflow.
// R2: the field is latched and returns to 00 only through a read of its register.
// R3: a set field bit with its mask bit set drives the interrupt output.
// R4: a new condition updates both field bits together in one cycle.
// R5: condition logic never writes 00 into the field itself.
// R6: between reads the field keeps the most severe code seen.
`timescale 1ns/10ps

module rx_link_fifo_irq_status (
    // clock, reset, enable
    input  wire logic                                clk,
    input  wire logic                                rst_b,
    input  wire logic                                ce,
    // receive link fifo
    input  wire logic                                halfFull,
    input  wire logic                                fifoFull,
    input  wire logic                                overflow,
    // wishbone slave
    input  wire logic                                cyc_i,
    input  wire logic                                stb_i,
    input  wire logic                                we_i,
    input  wire logic [rx_fifo_irq_pkg::ADR_W-1:0]   adr_i,
    input  wire logic [rx_fifo_irq_pkg::DAT_W-1:0]   dat_i,
    input  wire logic [3:0]                          sel_i,
    output      logic [rx_fifo_irq_pkg::DAT_W-1:0]   dat_o,
    output      logic                                ack_o,
    // interrupt
    output      logic                                irq
);
    import rx_fifo_irq_pkg::*;

    logic [CODE_W-1:0] condNow;
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [CODE_W-1:0] mask_r;
    logic [EVT_W-1:0]  evt_r;
    logic [EVT_W-1:0]  evtEn_r;
    logic [EVT_W-1:0]  evtSet;
    logic              access;
    logic              wrLane0;
    logic              rdClr;
    logic              irq_nxt;

    // ==========================================================
    // condition encoder
    rx_fifo_cond_encode u_encode (
        .halfFull (halfFull),
        .fifoFull (fifoFull),
        .overflow (overflow),
        .condNow  (condNow)
    );

    // ==========================================================
    // bus decode; one wait state, ack is a single-cycle pulse
    assign access  = cyc_i && stb_i && !ack_o;
    assign wrLane0 = access && we_i && sel_i[0];
    assign rdClr   = access && !we_i && (adr_i == ADR_STATUS);   // R2

    // ack follows every access, mapped or not
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_o <= 1'b0;
        end else if (ce) begin
            ack_o <= access;
        end
    end

    // read data captured with the ack; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dat_o <= DAT_ZERO;
        end else if (ce) begin
            dat_o <= DAT_ZERO;
            if (access && !we_i) begin
                unique case (adr_i)
                    ADR_STATUS: dat_o[CODE_MSB:CODE_LSB] <= code_r;
                    ADR_MASK:   dat_o[CODE_MSB:CODE_LSB] <= mask_r;
                    ADR_EVT:    dat_o[EVT_W-1:0]         <= evt_r;
                    ADR_EVT_EN: dat_o[EVT_W-1:0]         <= evtEn_r;
                    default:    dat_o                    <= DAT_ZERO;
                endcase
            end
        end
    end

    // ==========================================================
    // latched condition code; a condition in the clearing cycle wins
    always_comb begin
        code_nxt = code_r;
        if (rdClr) begin
            code_nxt = CODE_RST;                              // R2
        end
        if (condNow != COND_NORMAL) begin
            code_nxt = sevMax(code_nxt, condNow);             // R4 R5 R6
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            code_r <= CODE_RST;
        end else if (ce) begin
            code_r <= code_nxt;                               // R4
        end
    end

    // ==========================================================
    // mask for the code field, same bit layout as the status register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mask_r <= MASK_RST;
        end else if (ce && wrLane0 && adr_i == ADR_MASK) begin
            mask_r <= dat_i[CODE_MSB:CODE_LSB];
        end
    end

    // ==========================================================
    // sticky events: set each cycle the present code is half, full or overflow
    assign evtSet[EVT_HALF] = (condNow == COND_HALF);
    assign evtSet[EVT_FULL] = (condNow == COND_FULL);
    assign evtSet[EVT_OVF]  = (condNow == COND_OVF);

    // set beats a clear written in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            evt_r <= EVT_RST;
        end else if (ce) begin
            if (wrLane0 && adr_i == ADR_EVT_CLR) begin
                evt_r <= (evt_r & ~dat_i[EVT_W-1:0]) | evtSet;
            end else begin
                evt_r <= evt_r | evtSet;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            evtEn_r <= EVT_RST;
        end else if (ce && wrLane0 && adr_i == ADR_EVT_EN) begin
            evtEn_r <= dat_i[EVT_W-1:0];
        end
    end

    // ==========================================================
    // interrupt is registered, so it trails its cause by one cycle
    assign irq_nxt = (|(code_r & mask_r)) || (|(evt_r & evtEn_r));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= irq_nxt;                                   // R3
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !ce);

    sequence busReq;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence ackPulse;
        ack_o ##1 !ack_o;
    endsequence

    sequence statusRead;
        busReq and (!we_i && adr_i == ADR_STATUS);
    endsequence

    busAck_pulse_a: assert property (busReq |=> ackPulse)
        else $error("ack not a one-cycle pulse after request");

    codeEncode_ovf_a: assert property (overflow |=> code_r == COND_OVF)  // R1
        else $error("overflow not coded as 11");

    codeEncode_full_a: assert property                                  // R1
        (fifoFull && !overflow && code_r != COND_OVF |=> code_r == COND_FULL)
        else $error("full not coded as 10");

    codeHold_latch_a: assert property                                   // R2
        (code_r != COND_NORMAL && !rdClr |=> code_r != COND_NORMAL)
        else $error("code cleared without a read");

    readClear_code_a: assert property                                   // R2
        (statusRead ##0 condNow == COND_NORMAL |=> code_r == COND_NORMAL)
        else $error("read did not clear code");

    irqMask_level_a: assert property (|(code_r & mask_r) |=> irq)       // R3
        else $error("masked status did not raise irq");

    irqQuiet_idle_a: assert property                                    // R3
        (!(|(code_r & mask_r)) && !(|(evt_r & evtEn_r)) |=> !irq)
        else $error("irq without enabled status");

    bothBits_update_a: assert property                                  // R4
        (code_r != $past(code_r) && code_r != COND_NORMAL
            |-> code_r == $past(condNow))
        else $error("code update not taken whole");

    noLogic_zero_a: assert property                                     // R5
        ($past(code_r) != COND_NORMAL && code_r == COND_NORMAL |-> $past(rdClr))
        else $error("code went to 00 without a read");

    severity_keep_a: assert property                                    // R6
        (!rdClr |=> code_r >= $past(code_r))
        else $error("less severe code replaced a worse one");

endmodule : rx_link_fifo_irq_status

// File: testbench/fifo_flag_model.sv
/*
 * Behavioural receive link FIFO that produces the fill flags.
 * Assumes push and pop come from the bench on clk; a push into a full
 * FIFO is dropped and shows a one-cycle overflow pulse.
 */
`timescale 1ns/10ps

module fifo_flag_model #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // fifo traffic
    input  wire logic push,
    input  wire logic pop,
    // fill flags
    output      logic halfFull,
    output      logic fifoFull,
    output      logic overflow
);
    int fillCnt_r;

    // ==========================================================
    // fill count; overflow is a pulse, so the block must latch it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fillCnt_r <= 0;
            overflow  <= 1'b0;
        end else begin
            overflow <= push && (fillCnt_r == DEPTH);
            if (push && fillCnt_r < DEPTH) begin
                fillCnt_r <= fillCnt_r + 1;
            end else if (pop && fillCnt_r > 0) begin
                fillCnt_r <= fillCnt_r - 1;
            end
        end
    end

    // level flags follow the count
    assign halfFull = (fillCnt_r >= DEPTH / 2);
    assign fifoFull = (fillCnt_r == DEPTH);
endmodule : fifo_flag_model

// File: testbench/rx_link_fifo_irq_status_bench.sv
/*
 * Self-checking bench: Wishbone read/write tasks, FIFO traffic, irq checks.
 * Assumes the package constants and a one-cycle ack from the block.
 */
`timescale 1ns/10ps

module rx_link_fifo_irq_status_bench;
    import rx_fifo_irq_pkg::*;
    logic             clk, rst_b, ce, push, pop, cyc, stb, we, ack, irq, half, full, ovf;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] wdat, rdat;
    logic [3:0]       sel;
    int               error_cnt, tests_run;

    // ==========================================================
    // clock, reset, fifo model and block
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    fifo_flag_model #(.DEPTH(8)) u_fifo_flag_model (.clk(clk), .rst_b(rst_b), .push(push),
        .pop(pop), .halfFull(half), .fifoFull(full), .overflow(ovf));
    rx_link_fifo_irq_status u_rx_link_fifo_irq_status (.clk(clk), .rst_b(rst_b), .ce(ce),
        .halfFull(half), .fifoFull(full), .overflow(ovf), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
        .irq(irq));

    // ==========================================================
    // compare, bus cycle, traffic
    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // holds the request until ack is sampled high, then releases it
    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                      output logic [DAT_W-1:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (ack !== 1'b1) error_cnt++;
        {cyc, stb, we} <= 3'h0;
    endtask : wb

    task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
        logic [DAT_W-1:0] q;
        wb(1'b0, a, DAT_ZERO, q);
        check(q, exp);
    endtask : rd

    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        logic [DAT_W-1:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // push (dir=1) or pop n entries, then let code and irq settle
    task automatic move(input logic dir, input int n);
        @(posedge clk);
        {push, pop} <= {dir, !dir};
        repeat (n) @(posedge clk);
        {push, pop} <= 2'h0;
        repeat (3) @(posedge clk);
    endtask : move

    task automatic ckIrq(input logic exp);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask : ckIrq

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // ==========================================================
    // tests
    initial begin
        {rst_b, push, pop, cyc, stb, we, adr, wdat, sel} = '0;
        ce = 1'b1;
        error_cnt = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADR_STATUS, 32'h00);
        rd(ADR_MASK, 32'h00);
        ckIrq(1'b0);
        rd(8'h40, 32'h00);
        $display("test reset done");
        // half full: code stays while present, latched after it goes
        move(1'b1, 4);
        rd(ADR_STATUS, 32'h08);
        rd(ADR_STATUS, 32'h08);
        move(1'b0, 4);
        rd(ADR_STATUS, 32'h08);
        rd(ADR_STATUS, 32'h00);
        $display("test half done");
        // full then overflow: most severe code is kept, both bits at once
        move(1'b1, 8);
        move(1'b0, 8);
        rd(ADR_STATUS, 32'h10);
        move(1'b1, 9);
        move(1'b0, 8);
        rd(ADR_STATUS, 32'h18);
        rd(ADR_STATUS, 32'h00);
        $display("test severity done");
        // mask selects which code bits reach irq
        wr(ADR_MASK, 32'h08);
        move(1'b1, 8);
        ckIrq(1'b0);
        wr(ADR_MASK, 32'h10);
        ckIrq(1'b1);
        move(1'b0, 8);
        ckIrq(1'b1);
        rd(ADR_STATUS, 32'h10);
        ckIrq(1'b0);
        rd(ADR_MASK, 32'h10);
        $display("test mask done");
        // sticky events: start from a clean event register so irq is caused here
        wr(ADR_MASK, 32'h00);
        wr(ADR_EVT_CLR, 32'h07);
        wr(ADR_EVT_EN, 32'h04);
        rd(ADR_EVT_EN, 32'h04);
        ckIrq(1'b0);
        move(1'b1, 9);
        ckIrq(1'b1);
        move(1'b0, 8);
        rd(ADR_STATUS, 32'h18);
        rd(ADR_EVT, 32'h07);
        wr(ADR_EVT_CLR, 32'h07);
        rd(ADR_EVT, 32'h00);
        ckIrq(1'b0);
        $display("test events done");
        // clock enable low: a half-full episode inside the freeze is never seen
        wr(ADR_EVT_EN, 32'h01);
        @(posedge clk);
        ce <= 1'b0;
        move(1'b1, 4);
        ckIrq(1'b0);
        move(1'b0, 4);
        @(posedge clk);
        ce <= 1'b1;
        ckIrq(1'b0);
        rd(ADR_STATUS, 32'h00);
        rd(ADR_EVT, 32'h00);
        // a clear written while half full is still present loses to the set
        move(1'b1, 4);
        wr(ADR_EVT_CLR, 32'h07);
        rd(ADR_EVT, 32'h01);
        ckIrq(1'b1);
        $display("test freeze done");
        wrap_up();
    end
endmodule : rx_link_fifo_irq_status_bench
